//--- include/prhg_pkg.sv
// Constants, state encoding and health-test limits for the gated random source
package prhg_pkg;

   // Health test limits
   localparam int TF_RUN_LIMIT     = 32;   // Identical bits in a row that mean a dead source
   localparam int WIN_BITS         = 256;  // Raw bits per online test window
   localparam int ONES_MIN         = 96;   // Least count of ones per window
   localparam int ONES_MAX         = 160;  // Greatest count of ones per window
   localparam int INTERVAL_WINDOWS = 16;   // Windows per period in interval mode
   localparam int OCTET_BITS       = 8;    // Bits per delivered octet
   localparam int BUF_DEPTH        = 2;    // Entries of the output buffer

   // Generator life cycle
   typedef enum logic [1:0] {
      ST_OFF     = 2'b00,
      ST_STARTUP = 2'b01,
      ST_RUN     = 2'b10,
      ST_FAILED  = 2'b11
   } prhg_state_type;

endpackage : prhg_pkg

//--- hdl/prhg_buf.sv
// Two-entry valid/ready buffer for random octets, with flush
`timescale 1ns/100ps
module prhg_buf #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             flush,
   // Filling side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Draining side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   logic [WIDTH-1:0] data_q [0:1];
   logic [1:0]       cnt_q;
   logic             push;
   logic             pop;

   // Ready only while an entry is free, so a stalled reader fills it
   assign in_ready = (cnt_q != 2'h2);
   assign push     = in_valid && in_ready;
   assign pop      = out_valid && out_ready;
   assign out_data = data_q[0];

   // Occupancy; flush drops everything at once
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_q     <= 2'h0;
         out_valid <= 1'b0;
      end
      else if (flush)
      begin
         cnt_q     <= 2'h0;
         out_valid <= 1'b0;
      end
      else
      begin
         cnt_q     <= cnt_q + {1'b0, push} - {1'b0, pop};
         out_valid <= (cnt_q + {1'b0, push} - {1'b0, pop}) != 2'h0;
      end
   end

   // Entry storage; head shifts forward on pop
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         data_q[0] <= '0;
         data_q[1] <= '0;
      end
      else if (flush)
      begin
         data_q[0] <= '0;
         data_q[1] <= '0;
      end
      else
      begin
         if (pop)
         begin
            data_q[0] <= (cnt_q == 2'h2) ? data_q[1] : in_data;
            if (push && cnt_q == 2'h2)
               data_q[1] <= in_data;
         end
         else if (push)
         begin
            if (cnt_q == 2'h0)
               data_q[0] <= in_data;
            else
               data_q[1] <= in_data;
         end
      end
   end

endmodule : prhg_buf

//--- hdl/prhg_top.sv
// Physical random source with total-failure and online health gating
`timescale 1ns/100ps
module prhg_top #(
   parameter int TF_RUN_LIMIT     = prhg_pkg::TF_RUN_LIMIT,
   parameter int WIN_BITS         = prhg_pkg::WIN_BITS,
   parameter int ONES_MIN         = prhg_pkg::ONES_MIN,
   parameter int ONES_MAX         = prhg_pkg::ONES_MAX,
   parameter int INTERVAL_WINDOWS = prhg_pkg::INTERVAL_WINDOWS
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Raw noise source
   input  wire logic       noise_bit,
   input  wire logic       noise_valid,
   // Software control
   input  wire logic       rng_enable,
   input  wire logic       test_continuous,
   input  wire logic       selftest_start,
   // Octet stream
   output logic [7:0]      rng_data,
   output logic            rng_valid,
   input  wire logic       rng_ready,
   // Health status
   output logic            healthy,
   output logic            tf_fail,
   output logic            ol_fail,
   output logic            selftest_busy,
   output logic            selftest_pass,
   output logic            selftest_fail
);

   localparam int RW = $clog2(TF_RUN_LIMIT + 1);
   localparam int WW = $clog2(WIN_BITS);
   localparam int OW = $clog2(WIN_BITS + 1);
   localparam int GW = $clog2(INTERVAL_WINDOWS);
   localparam logic [RW-1:0] RUN_LAST = RW'(TF_RUN_LIMIT - 1);
   localparam logic [WW-1:0] WIN_LAST = WW'(WIN_BITS - 1);
   localparam logic [OW-1:0] OMIN     = OW'(ONES_MIN);
   localparam logic [OW-1:0] OMAX     = OW'(ONES_MAX);
   localparam logic [GW-1:0] GAP_LAST = GW'(INTERVAL_WINDOWS - 1);

   prhg_pkg::prhg_state_type state_q, state_d;

   logic          en_q;
   logic          last_bit_q;
   logic [RW-1:0] run_q;
   logic [WW-1:0] win_q;
   logic [OW-1:0] ones_q;
   logic [OW-1:0] ones_fin;
   logic [GW-1:0] gap_q;
   logic          tf_hit;
   logic          win_done;
   logic          win_active;
   logic          defect;
   logic          live;
   logic [7:0]    shift_q;
   logic [2:0]    bit_cnt_q;
   logic          oct_full_q;
   logic          buf_ready;
   logic          flush;
   logic [WW-1:0] st_cnt_q;
   logic          st_fault_q;

   assign live = (state_q == prhg_pkg::ST_STARTUP) || (state_q == prhg_pkg::ST_RUN);

   // Run-length watch on raw bits; a stuck source shows as a long run
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         last_bit_q <= 1'b0;
         run_q      <= '0;
      end
      else if (state_q == prhg_pkg::ST_OFF)
         run_q <= '0;
      else if (noise_valid)
      begin
         last_bit_q <= noise_bit;
         run_q      <= (noise_bit == last_bit_q && run_q != '0) ? run_q + 1'b1 : RW'(1);
      end
   end
   assign tf_hit = live && noise_valid && noise_bit == last_bit_q && run_q == RUN_LAST;

   // Window counting for the online balance test
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         win_q  <= '0;
         ones_q <= '0;
         gap_q  <= '0;
      end
      else if (state_q == prhg_pkg::ST_OFF)
      begin
         win_q  <= '0;
         ones_q <= '0;
         gap_q  <= '0;
      end
      else if (noise_valid)
      begin
         win_q  <= win_done ? '0 : win_q + 1'b1;
         ones_q <= win_done ? '0 : ones_q + OW'(noise_bit);
         if (win_done)
            gap_q <= (gap_q == GAP_LAST) ? '0 : gap_q + 1'b1;
      end
   end
   assign win_done = noise_valid && win_q == WIN_LAST;
   assign ones_fin = ones_q + OW'(noise_bit);
   // Interval mode tests one window per period; start-up always tests
   assign win_active = test_continuous || gap_q == '0 ||
                       state_q == prhg_pkg::ST_STARTUP;
   // Balance bounds hold the bias low enough for the entropy target
   assign defect = live && win_done && win_active &&
                   (ones_fin < OMIN || ones_fin > OMAX);

   // Life cycle of the generator
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         prhg_pkg::ST_OFF:
            if (rng_enable && !en_q)
               state_d = prhg_pkg::ST_STARTUP;
         prhg_pkg::ST_STARTUP:
            if (!rng_enable)
               state_d = prhg_pkg::ST_OFF;
            else if (tf_hit || defect)
               state_d = prhg_pkg::ST_FAILED;
            else if (win_done)
               state_d = prhg_pkg::ST_RUN;
         prhg_pkg::ST_RUN:
            if (!rng_enable)
               state_d = prhg_pkg::ST_OFF;
            else if (tf_hit || defect)
               state_d = prhg_pkg::ST_FAILED;
         prhg_pkg::ST_FAILED:
            if (!rng_enable)
               state_d = prhg_pkg::ST_OFF;
         default:
            state_d = prhg_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_q <= prhg_pkg::ST_OFF;
         en_q    <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         en_q    <= rng_enable;
      end
   end

   // Status flags; failure causes stay set until the generator is restarted
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         healthy <= 1'b0;
         tf_fail <= 1'b0;
         ol_fail <= 1'b0;
      end
      else
      begin
         healthy <= state_d == prhg_pkg::ST_RUN;
         if (tf_hit)
            tf_fail <= 1'b1;
         else if (state_d == prhg_pkg::ST_STARTUP && state_q == prhg_pkg::ST_OFF)
            tf_fail <= 1'b0;
         if (defect)
            ol_fail <= 1'b1;
         else if (state_d == prhg_pkg::ST_STARTUP && state_q == prhg_pkg::ST_OFF)
            ol_fail <= 1'b0;
      end
   end

   // Octet assembly; a full octet waits for buffer space, later bits are skipped
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         shift_q    <= 8'h00;
         bit_cnt_q  <= 3'h0;
         oct_full_q <= 1'b0;
      end
      else if (flush)
      begin
         shift_q    <= 8'h00;
         bit_cnt_q  <= 3'h0;
         oct_full_q <= 1'b0;
      end
      else if (oct_full_q)
         oct_full_q <= !buf_ready;
      else if (noise_valid)
      begin
         shift_q    <= {shift_q[6:0], noise_bit};
         bit_cnt_q  <= bit_cnt_q + 1'b1;
         oct_full_q <= bit_cnt_q == 3'h7;
      end
   end

   // Anything outside healthy running, now or from the next edge, drops held data
   assign flush = state_q != prhg_pkg::ST_RUN || state_d != prhg_pkg::ST_RUN ||
                  tf_hit || defect;

   prhg_buf #(
      .WIDTH     (prhg_pkg::OCTET_BITS)
   ) u_buf (
      .clk       (clk),
      .reset     (reset),
      .flush     (flush),
      .in_data   (shift_q),
      .in_valid  (oct_full_q),
      .in_ready  (buf_ready),
      .out_data  (rng_data),
      .out_valid (rng_valid),
      .out_ready (rng_ready)
   );

   // Software-started failure test over one window of raw bits
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         selftest_busy <= 1'b0;
         selftest_pass <= 1'b0;
         selftest_fail <= 1'b0;
         st_cnt_q      <= '0;
         st_fault_q    <= 1'b0;
      end
      else if (selftest_start && !selftest_busy)
      begin
         selftest_busy <= 1'b1;
         selftest_pass <= 1'b0;
         selftest_fail <= 1'b0;
         st_cnt_q      <= '0;
         st_fault_q    <= 1'b0;
      end
      else if (selftest_busy && noise_valid)
      begin
         st_cnt_q   <= st_cnt_q + 1'b1;
         // Uses the run watch, whose hits only count while the generator is live
         st_fault_q <= st_fault_q || tf_hit || !live;
         if (st_cnt_q == WIN_LAST)
         begin
            selftest_busy <= 1'b0;
            selftest_pass <= !(st_fault_q || tf_hit || !live);
            selftest_fail <= st_fault_q || tf_hit || !live;
         end
      end
   end

   // Checks on the gating behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_fail_seen;
      tf_hit || defect;
   endsequence

   tf_to_failed_a: assert property (tf_hit && rng_enable |=> state_q == prhg_pkg::ST_FAILED)
      else $error("total failure did not stop the generator");
   failed_no_out_a: assert property (state_q == prhg_pkg::ST_FAILED |-> !rng_valid)
      else $error("octet offered after failure");
   fail_drops_a: assert property (s_fail_seen |=> !rng_valid [*2])
      else $error("buffered octet survived a failure");
   defect_flag_a: assert property (defect |=> ol_fail && !healthy)
      else $error("online defect not flagged");
   startup_gate_a: assert property (state_q != prhg_pkg::ST_RUN |-> !rng_valid)
      else $error("octet offered before start-up passed");
   sticky_fail_a: assert property (state_q == prhg_pkg::ST_FAILED && rng_enable
                                   |=> state_q == prhg_pkg::ST_FAILED)
      else $error("failure released without restart");
   octet_hold_a: assert property (rng_valid && !rng_ready && !flush
                                  |=> rng_valid && $stable(rng_data))
      else $error("stalled octet changed");
   start_entry_a: assert property (state_q == prhg_pkg::ST_OFF && rng_enable && !en_q
                                   |=> state_q == prhg_pkg::ST_STARTUP)
      else $error("enable did not start the failure check");
   cont_window_a: assert property (test_continuous && win_done && live && rng_enable &&
                                   (ones_fin < OMIN || ones_fin > OMAX)
                                   |=> state_q == prhg_pkg::ST_FAILED)
      else $error("continuous mode let a biased window pass");
   selftest_end_a: assert property ($fell(selftest_busy) |-> selftest_pass != selftest_fail)
      else $error("self-test result not exactly one of pass or fail");

endmodule : prhg_top

//--- tb/prhg_tb.sv
// Self-checking bench for the health-gated random octet source
`timescale 1ns/100ps
module tb;

   // Short health limits keep the run brief
   localparam int TFL = 8;
   localparam int WIN = 16;

   // Stimulus and observed signals
   logic       clk             = 1'b0;
   logic       reset           = 1'b1;
   logic       noise_bit       = 1'b0;
   logic       noise_valid     = 1'b0;
   logic       rng_enable      = 1'b0;
   logic       test_continuous = 1'b1;
   logic       selftest_start  = 1'b0;
   logic       rng_ready       = 1'b0;
   logic [7:0] rng_data;
   logic       rng_valid;
   logic       healthy;
   logic       tf_fail;
   logic       ol_fail;
   logic       selftest_busy;
   logic       selftest_pass;
   logic       selftest_fail;
   int         num_errors      = 0;
   int         checks          = 0;

   // Device under test
   prhg_top #(
      .TF_RUN_LIMIT     (TFL),
      .WIN_BITS         (WIN),
      .ONES_MIN         (4),
      .ONES_MAX         (12),
      .INTERVAL_WINDOWS (2)
   ) u_prhg_top (
      .clk             (clk),
      .reset           (reset),
      .noise_bit       (noise_bit),
      .noise_valid     (noise_valid),
      .rng_enable      (rng_enable),
      .test_continuous (test_continuous),
      .selftest_start  (selftest_start),
      .rng_data        (rng_data),
      .rng_valid       (rng_valid),
      .rng_ready       (rng_ready),
      .healthy         (healthy),
      .tf_fail         (tf_fail),
      .ol_fail         (ol_fail),
      .selftest_busy   (selftest_busy),
      .selftest_pass   (selftest_pass),
      .selftest_fail   (selftest_fail)
   );

   // 100 ns clock
   always #50 clk = ~clk;

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Verdict and end of run
   task automatic summarize;
      $display("checks %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   // One raw bit per edge, MSB first; an idle cycle follows the octet
   task automatic feed(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge clk);
         noise_bit   <= b[i];
         noise_valid <= 1'b1;
      end
      @(posedge clk);
      noise_valid <= 1'b0;
   endtask : feed

   // Let edges pass, then look once their updates have landed
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   // Drop enable through OFF, then raise it to start fresh tests
   task automatic restart(input logic cont);
      @(posedge clk);
      rng_enable      <= 1'b0;
      test_continuous <= cont;
      settle(2);
      @(posedge clk);
      rng_enable <= 1'b1;
      settle(2);
   endtask : restart

   // Single-cycle pop of the head octet
   task automatic pop;
      @(posedge clk);
      rng_ready <= 1'b1;
      @(posedge clk);
      rng_ready <= 1'b0;
      #1;
   endtask : pop

   // Pulse the software failure test
   task automatic start_selftest;
      @(posedge clk);
      selftest_start <= 1'b1;
      @(posedge clk);
      selftest_start <= 1'b0;
      #1;
   endtask : start_selftest

   // Nothing released before the generator is enabled
   task automatic t_reset;
      settle(2);
      check({2'h0, rng_valid, healthy, tf_fail, ol_fail, selftest_pass, selftest_fail}, 8'h00);
      $display("test reset done");
   endtask : t_reset

   // Start-up window, octet order, back-pressure and draining
   task automatic t_stream;
      restart(1'b1);
      feed(8'hA5);
      #1;
      check(8'(rng_valid), 8'h00);
      feed(8'hA5);
      settle(2);
      check(8'(healthy), 8'h01);
      check(8'(rng_valid), 8'h00);
      feed(8'h3C);
      feed(8'h5A);
      settle(2);
      check(8'(rng_valid), 8'h01);
      check(rng_data, 8'h3C);
      pop();
      check(rng_data, 8'h5A);
      pop();
      check(8'(rng_valid), 8'h00);
      $display("test stream done");
   endtask : t_stream

   // Dead source while an octet waits; later good bits release nothing
   task automatic t_total_fail;
      feed(8'h96);
      settle(2);
      check(8'(rng_valid), 8'h01);
      feed(8'h00);
      settle(2);
      check(8'(tf_fail), 8'h01);
      check(8'(healthy), 8'h00);
      check(8'(rng_valid), 8'h00);
      @(posedge clk);
      rng_ready <= 1'b1;
      feed(8'hA5);
      feed(8'hA5);
      settle(3);
      check(8'(rng_valid), 8'h00);
      check(8'(healthy), 8'h00);
      @(posedge clk);
      rng_ready <= 1'b0;
      $display("test total failure done");
   endtask : t_total_fail

   // Biased start-up window in interval mode is still caught
   task automatic t_online;
      restart(1'b0);
      check(8'({tf_fail, ol_fail}), 8'h00);
      feed(8'hFE);
      feed(8'hFE);
      settle(2);
      check(8'({ol_fail, tf_fail, healthy}), 8'h04);
      feed(8'hA5);
      feed(8'hA5);
      settle(3);
      check(8'({healthy, rng_valid}), 8'h00);
      $display("test online defect done");
   endtask : t_online

   // Interval mode lets an untested biased window by; continuous mode catches it
   task automatic t_interval;
      restart(1'b0);
      feed(8'hA5);
      feed(8'h5A);
      feed(8'hFE);
      feed(8'hFE);
      settle(2);
      check(8'({ol_fail, healthy, rng_valid}), 8'h03);
      check(rng_data, 8'hFE);
      feed(8'hFE);
      feed(8'hFE);
      settle(2);
      check(8'({ol_fail, healthy, rng_valid}), 8'h04);
      restart(1'b1);
      feed(8'hA5);
      feed(8'h5A);
      feed(8'hFE);
      feed(8'hFE);
      settle(2);
      check(8'({ol_fail, healthy, rng_valid}), 8'h04);
      $display("test interval done");
   endtask : t_interval

   // Software test passes on a good source and fails on a dead one
   task automatic t_selftest;
      restart(1'b1);
      feed(8'hA5);
      feed(8'hA5);
      start_selftest();
      check(8'(selftest_busy), 8'h01);
      feed(8'hA5);
      feed(8'h3C);
      #1;
      check(8'({selftest_busy, selftest_pass, selftest_fail}), 8'h02);
      start_selftest();
      feed(8'h00);
      feed(8'hA5);
      #1;
      check(8'({selftest_busy, selftest_pass, selftest_fail}), 8'h01);
      check(8'(tf_fail), 8'h01);
      $display("test selftest done");
   endtask : t_selftest

   // Main sequence: reset held four cycles
   initial
   begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_stream();
      t_total_fail();
      t_online();
      t_interval();
      t_selftest();
      summarize();
   end

   // Watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #(5000 * 100);
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      summarize();
   end

endmodule : tb
